// *** rtl/pqm_bus_if.sv ***
// register bus between host and device
`timescale 1ns/1ps
interface pqm_bus_if;
	logic [pqm_pkg::ADDR_W-1:0] addr;
	logic [pqm_pkg::DATA_W-1:0] wdata;
	logic [pqm_pkg::DATA_W-1:0] rdata;
	logic                       wr;
	logic                       rd;
	modport host (output addr, output wdata, output wr, output rd, input rdata);
	modport dev (input addr, input wdata, input wr, input rd, output rdata);
endinterface : pqm_bus_if

// *** rtl/pqm_dev.sv ***
// device end: packet memory manager, queues and power gating
// Operation
// R1 - host sets clock power enable to wake
// R2 - power enable ungates rx, tx, core clocks
// R3 - host clears phy powerdown, phy resumes
// R4 - host resets mmu, restores context, then enables
// R5 - transmit only while tx enable set
// R6 - receive only after rx enable set
// R7 - allocate command reserves requested packet memory
// R8 - success sets done flag and result number
// R9 - host loads number, pointer, then frame data; the host here loads number and pointer only and writes no frame data
// R10 - enqueue pushes packet number register to fifo
// R11 - start gated by tx enable and deferral
// R12 - completion stores status, moves to done fifo
// R13 - tx flag while done fifo not empty
// R14 - ports show done head; status readable
// R15 - release frees memory; acknowledge pops done
// R16 - rx start allocates number, pages on demand
// R17 - overrun drops frame and frees memory
// R18 - end stores status word and byte count
// R19 - good crc queues; rx flag while queued
// R20 - bad crc frees memory, no queue
// R21 - ports show receive fifo head
// R22 - remove release pops rx head, frees
// R23 - auto release frees good transmits directly
// R24 - tx empty flag while tx fifo empty
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module pqm_dev #(
	parameter int PKTS  = pqm_pkg::PKTS,
	parameter int PAGES = pqm_pkg::PAGES,
	parameter int PN_W  = $clog2(PKTS)
) (
	// clock and reset
	input  wire logic            mclk_in,
	input  wire logic            rst_n_in,
	// register side
	pqm_bus_if.dev               bus,
	// mac transmit
	input  wire logic            full_duplex_in,
	input  wire logic            defer_in,
	input  wire logic            tx_done_in,
	input  wire logic            tx_ok_in,
	input  wire logic [15:0]     tx_status_in,
	output logic                 tx_start_out,
	output logic      [PN_W-1:0] tx_pnr_out,
	// mac receive
	input  wire logic            rx_start_in,
	input  wire logic            rx_page_req_in,
	input  wire logic            rx_overrun_in,
	input  wire logic            rx_end_in,
	input  wire logic            rx_crc_ok_in,
	input  wire logic [15:0]     rx_status_in,
	input  wire logic [15:0]     rx_bytes_in,
	output logic                 rx_drop_out,
	// power
	output logic                 core_clk_en_out,
	output logic                 rx_clk_en_out,
	output logic                 tx_clk_en_out,
	output logic                 phy_powerdown_out
);
	localparam int PG_W = $clog2(PAGES + 1);
	generate
		if (PKTS < 2 || PN_W != $clog2(PKTS) || PN_W > 7 || (1 << PN_W) != PKTS) begin : g_chk
			$error("pqm_dev: packet count must be a power of two up to 128");
		end
	endgenerate
	function automatic logic [PN_W:0] first_free(input logic [PKTS-1:0] u);
		logic [PN_W:0] r;
		r = '0;
		for (int i = PKTS - 1; i >= 0; i--) begin
			if (!u[i]) begin
				r = {1'b1, PN_W'(i)};
			end
		end
		return r;
	endfunction : first_free
	logic [15:0] cfg_r, cfg_nxt, tcr_r, tcr_nxt, rcr_r, rcr_nxt, ctl_r, ctl_nxt;
	logic [15:0] phy_r, phy_nxt, ptr_r, ptr_nxt, rdata_r, rdata_nxt, rv;
	logic [15:0] stat_r [PKTS];
	logic [15:0] stat_nxt [PKTS];
	logic [15:0] cnt_r [PKTS];
	logic [15:0] cnt_nxt [PKTS];
	logic [PG_W-1:0] pg_r [PKTS];
	logic [PG_W-1:0] pg_nxt [PKTS];
	logic [PG_W-1:0] free_r, free_nxt, apg_r, apg_nxt;
	logic [PKTS-1:0] used_r, used_nxt, fmask;
	logic [PN_W-1:0] pnr_r, pnr_nxt, arr_r, arr_nxt, txp_r, txp_nxt, rxp_r, rxp_nxt;
	logic [PN_W-1:0] txq_head, dn_head, rxq_head;
	logic [PN_W:0]   ff;
	logic [2:0]      cmd;
	logic apend_r, apend_nxt, adone_r, adone_nxt, tbusy_r, tbusy_nxt, ract_r, ract_nxt;
	logic tst_r, tst_nxt, rdrop_r, rdrop_nxt, mmu_wr, mmu_clr;
	logic txq_push, txq_pop, txq_empty, dn_push, dn_pop, dn_empty, rxq_push, rxq_pop, rxq_empty;
	assign bus.rdata         = rdata_r;
	assign tx_start_out      = tst_r;
	assign tx_pnr_out        = txp_r;
	assign rx_drop_out       = rdrop_r;
	assign core_clk_en_out   = cfg_r[pqm_pkg::CFG_PWR_BIT];
	assign rx_clk_en_out     = cfg_r[pqm_pkg::CFG_PWR_BIT];
	assign tx_clk_en_out     = cfg_r[pqm_pkg::CFG_PWR_BIT];
	assign phy_powerdown_out = phy_r[pqm_pkg::PHY_PDN_BIT];
	pqm_fifo #(.W(PN_W), .DEPTH(PKTS)) u_txq (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .clear_in(mmu_clr),
		.push_in(txq_push), .data_in(pnr_r), .pop_in(txq_pop), .head_out(txq_head), .empty_out(txq_empty));
	pqm_fifo #(.W(PN_W), .DEPTH(PKTS)) u_done (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .clear_in(mmu_clr),
		.push_in(dn_push), .data_in(txp_r), .pop_in(dn_pop), .head_out(dn_head), .empty_out(dn_empty));
	pqm_fifo #(.W(PN_W), .DEPTH(PKTS)) u_rxq (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .clear_in(mmu_clr),
		.push_in(rxq_push), .data_in(rxp_r), .pop_in(rxq_pop), .head_out(rxq_head), .empty_out(rxq_empty));
	always_comb begin
		cfg_nxt = cfg_r; tcr_nxt = tcr_r; rcr_nxt = rcr_r; ctl_nxt = ctl_r; phy_nxt = phy_r;
		ptr_nxt = ptr_r; pnr_nxt = pnr_r; arr_nxt = arr_r; txp_nxt = txp_r; rxp_nxt = rxp_r;
		stat_nxt = stat_r; cnt_nxt = cnt_r; pg_nxt = pg_r; free_nxt = free_r; apg_nxt = apg_r;
		used_nxt = used_r; apend_nxt = apend_r; adone_nxt = adone_r; tbusy_nxt = tbusy_r;
		ract_nxt = ract_r; tst_nxt = 1'b0; rdrop_nxt = 1'b0; fmask = '0; mmu_clr = 1'b0;
		txq_push = 1'b0; txq_pop = 1'b0; dn_push = 1'b0; dn_pop = 1'b0; rxq_push = 1'b0; rxq_pop = 1'b0;
		cmd    = bus.wdata[pqm_pkg::MMU_CMD_LSB +: 3];
		mmu_wr = bus.wr && bus.addr == pqm_pkg::REG_MMU;
		// register writes
		if (bus.wr) begin
			case (bus.addr)
				pqm_pkg::REG_CONFIG: cfg_nxt = bus.wdata; // [R1] [R2]
				pqm_pkg::REG_PNR:    pnr_nxt = bus.wdata[PN_W-1:0];
				pqm_pkg::REG_PTR:    ptr_nxt = bus.wdata;
				pqm_pkg::REG_TCR:    tcr_nxt = bus.wdata;
				pqm_pkg::REG_RCR:    rcr_nxt = bus.wdata;
				pqm_pkg::REG_CTRL:   ctl_nxt = bus.wdata;
				pqm_pkg::REG_PHY0:   phy_nxt = bus.wdata; // [R3]
				pqm_pkg::REG_INT: begin
					dn_pop = bus.wdata[pqm_pkg::INT_TX_BIT]; // [R15]
					if (bus.wdata[pqm_pkg::INT_ALLOC_BIT]) begin
						adone_nxt = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// mmu commands
		if (mmu_wr) begin
			case (cmd)
				pqm_pkg::CMD_ALLOC: begin
					apend_nxt = 1'b1; // [R7]
					apg_nxt   = PG_W'(bus.wdata[pqm_pkg::N_W-1:pqm_pkg::PAGE_SH]) + PG_W'(1);
				end
				pqm_pkg::CMD_ENQ:     txq_push = 1'b1; // [R10]
				pqm_pkg::CMD_RELEASE: fmask[pnr_r] = 1'b1; // [R15]
				pqm_pkg::CMD_RMREL: begin
					if (!rxq_empty) begin
						rxq_pop          = 1'b1; // [R22]
						fmask[rxq_head]  = 1'b1;
					end
				end
				pqm_pkg::CMD_RESET: mmu_clr = 1'b1; // [R4]
				default: ;
			endcase
		end
		// transmit hand-off and completion
		if (!tbusy_r && !txq_empty && tcr_r[pqm_pkg::TCR_EN_BIT] && cfg_r[pqm_pkg::CFG_PWR_BIT]
			&& (full_duplex_in || !defer_in)) begin // [R5] [R11]
			txq_pop   = 1'b1;
			tbusy_nxt = 1'b1;
			txp_nxt   = txq_head;
			tst_nxt   = 1'b1;
		end
		if (tbusy_r && tx_done_in) begin
			tbusy_nxt      = 1'b0;
			stat_nxt[txp_r] = tx_status_in; // [R12]
			if (ctl_r[pqm_pkg::CTRL_AREL_BIT] && tx_ok_in) begin
				fmask[txp_r] = 1'b1; // [R23]
			end else begin
				dn_push = 1'b1; // [R12]
			end
		end
		// receive frame end or loss
		if (ract_r) begin
			if (rx_overrun_in || (rx_page_req_in && free_r == '0)) begin
				ract_nxt      = 1'b0; // [R17]
				fmask[rxp_r]  = 1'b1;
				rdrop_nxt     = 1'b1;
			end else if (rx_end_in) begin
				ract_nxt        = 1'b0;
				stat_nxt[rxp_r] = rx_status_in; // [R18]
				cnt_nxt[rxp_r]  = rx_bytes_in;
				if (rx_crc_ok_in) begin
					rxq_push = 1'b1; // [R19]
				end else begin
					fmask[rxp_r] = 1'b1; // [R20]
					rdrop_nxt    = 1'b1;
				end
			end
		end
		// frees before allocations
		for (int i = 0; i < PKTS; i++) begin
			if (fmask[i] && used_r[i]) begin
				used_nxt[i] = 1'b0;
				free_nxt    = free_nxt + pg_r[i];
				pg_nxt[i]   = '0;
			end
		end
		if (ract_nxt && rx_page_req_in) begin
			pg_nxt[rxp_r] = pg_nxt[rxp_r] + PG_W'(1); // [R16]
			free_nxt      = free_nxt - PG_W'(1);
		end
		ff = first_free(used_nxt);
		if (rx_start_in && !ract_r && rcr_r[pqm_pkg::RCR_EN_BIT] && cfg_r[pqm_pkg::CFG_PWR_BIT]) begin // [R6]
			if (ff[PN_W] && free_nxt != '0) begin
				ract_nxt                  = 1'b1; // [R16]
				rxp_nxt                   = ff[PN_W-1:0];
				used_nxt[ff[PN_W-1:0]]    = 1'b1;
				pg_nxt[ff[PN_W-1:0]]      = PG_W'(1);
				free_nxt                  = free_nxt - PG_W'(1);
			end else begin
				rdrop_nxt = 1'b1; // [R17]
			end
		end
		ff = first_free(used_nxt);
		if (apend_r && ff[PN_W] && free_nxt >= apg_r) begin
			apend_nxt              = mmu_wr && cmd == pqm_pkg::CMD_ALLOC; // [R7]
			adone_nxt              = 1'b1; // [R8]
			arr_nxt                = ff[PN_W-1:0];
			used_nxt[ff[PN_W-1:0]] = 1'b1;
			pg_nxt[ff[PN_W-1:0]]   = apg_r;
			free_nxt               = free_nxt - apg_r;
		end
		if (mmu_clr) begin
			used_nxt  = '0;
			free_nxt  = PG_W'(PAGES);
			apend_nxt = 1'b0;
			ract_nxt  = 1'b0;
			for (int i = 0; i < PKTS; i++) begin
				pg_nxt[i] = '0;
			end
		end
		// read data, valid one cycle after the strobe
		rv = '0;
		case (bus.addr)
			pqm_pkg::REG_CONFIG: rv = cfg_r;
			pqm_pkg::REG_PNR:    rv[PN_W-1:0] = pnr_r;
			pqm_pkg::REG_ARR: begin
				rv[PN_W-1:0]               = arr_r; // [R8]
				rv[pqm_pkg::ARR_BUSY_BIT]  = apend_r;
			end
			pqm_pkg::REG_FIFO: begin
				rv[pqm_pkg::FIFO_RXE_BIT]          = rxq_empty;
				rv[pqm_pkg::FIFO_RX_LSB +: PN_W]   = rxq_head; // [R21]
				rv[pqm_pkg::FIFO_TXE_BIT]          = dn_empty;
				rv[pqm_pkg::FIFO_TX_LSB +: PN_W]   = dn_head; // [R14]
			end
			pqm_pkg::REG_PTR:  rv = ptr_r;
			pqm_pkg::REG_DATA: rv = ptr_r[pqm_pkg::PTR_WORD_BIT] ? cnt_r[pnr_r] : stat_r[pnr_r]; // [R14]
			pqm_pkg::REG_INT: begin
				rv[pqm_pkg::INT_RX_BIT]    = !rxq_empty; // [R19]
				rv[pqm_pkg::INT_TX_BIT]    = !dn_empty; // [R13]
				rv[pqm_pkg::INT_TXE_BIT]   = txq_empty; // [R24]
				rv[pqm_pkg::INT_ALLOC_BIT] = adone_r; // [R8]
			end
			pqm_pkg::REG_TCR:  rv = tcr_r;
			pqm_pkg::REG_RCR:  rv = rcr_r;
			pqm_pkg::REG_CTRL: rv = ctl_r;
			pqm_pkg::REG_PHY0: rv = phy_r;
			default: rv = '0;
		endcase
		rdata_nxt = bus.rd ? rv : '0;
	end
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_r <= pqm_pkg::CONFIG_RST; tcr_r <= pqm_pkg::CTL_RST; rcr_r <= pqm_pkg::CTL_RST;
			ctl_r <= pqm_pkg::CTL_RST; phy_r <= pqm_pkg::PHY0_RST; ptr_r <= '0; rdata_r <= '0;
			for (int i = 0; i < PKTS; i++) begin
				stat_r[i] <= '0;
				cnt_r[i]  <= '0;
				pg_r[i]   <= '0;
			end
			free_r <= PG_W'(PAGES); apg_r <= '0; used_r <= '0; pnr_r <= '0; arr_r <= '0;
			txp_r <= '0; rxp_r <= '0; apend_r <= 1'b0; adone_r <= 1'b0; tbusy_r <= 1'b0;
			ract_r <= 1'b0; tst_r <= 1'b0; rdrop_r <= 1'b0;
		end else begin
			cfg_r <= cfg_nxt; tcr_r <= tcr_nxt; rcr_r <= rcr_nxt; ctl_r <= ctl_nxt; phy_r <= phy_nxt;
			ptr_r <= ptr_nxt; rdata_r <= rdata_nxt; stat_r <= stat_nxt; cnt_r <= cnt_nxt; pg_r <= pg_nxt;
			free_r <= free_nxt; apg_r <= apg_nxt; used_r <= used_nxt; pnr_r <= pnr_nxt; arr_r <= arr_nxt;
			txp_r <= txp_nxt; rxp_r <= rxp_nxt; apend_r <= apend_nxt; adone_r <= adone_nxt;
			tbusy_r <= tbusy_nxt; ract_r <= ract_nxt; tst_r <= tst_nxt; rdrop_r <= rdrop_nxt;
		end
	end
endmodule : pqm_dev

// *** rtl/pqm_fifo.sv ***
// packet number fifo
`timescale 1ns/1ps
module pqm_fifo #(
	parameter int W     = 3,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic         mclk_in,
	input  wire logic         rst_n_in,
	// control
	input  wire logic         clear_in,
	input  wire logic         push_in,
	input  wire logic [W-1:0] data_in,
	input  wire logic         pop_in,
	// state
	output logic      [W-1:0] head_out,
	output logic              empty_out
);
	localparam int AW = $clog2(DEPTH);
	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_chk
			$error("pqm_fifo: depth must be a power of two");
		end
	endgenerate
	logic [W-1:0] mem_r [DEPTH];
	logic [W-1:0] mem_nxt [DEPTH];
	logic [AW-1:0] rp_r, rp_nxt, wp_r, wp_nxt;
	logic [AW:0]   cnt_r, cnt_nxt;
	logic          do_push, do_pop;
	assign head_out  = mem_r[rp_r];
	assign empty_out = (cnt_r == '0);
	always_comb begin
		mem_nxt = mem_r;
		do_pop  = pop_in && (cnt_r != '0);
		do_push = push_in && (cnt_r != (AW+1)'(DEPTH) || do_pop);
		rp_nxt  = do_pop ? rp_r + 1'b1 : rp_r;
		wp_nxt  = do_push ? wp_r + 1'b1 : wp_r;
		cnt_nxt = cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
		if (do_push) begin
			mem_nxt[wp_r] = data_in;
		end
		if (clear_in) begin
			rp_nxt  = '0;
			wp_nxt  = '0;
			cnt_nxt = '0;
		end
	end
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= '0;
			end
			rp_r  <= '0;
			wp_r  <= '0;
			cnt_r <= '0;
		end else begin
			mem_r <= mem_nxt;
			rp_r  <= rp_nxt;
			wp_r  <= wp_nxt;
			cnt_r <= cnt_nxt;
		end
	end
endmodule : pqm_fifo

// *** rtl/pqm_host.sv ***
// host end: driver sequencer over the register bus
`timescale 1ns/1ps
module pqm_host #(
	parameter int PN_W = $clog2(pqm_pkg::PKTS)
) (
	// clock and reset
	input  wire logic        mclk_in,
	input  wire logic        rst_n_in,
	// register side
	pqm_bus_if.host          bus,
	// software port
	input  wire logic [3:0]  sw_addr_in,
	input  wire logic [15:0] sw_wdata_in,
	input  wire logic        sw_wr_in,
	input  wire logic        sw_rd_in,
	output logic      [15:0] sw_rdata_out
);
	generate
		if (PN_W < 1 || PN_W > 7) begin : g_chk
			$error("pqm_host: packet number width out of range");
		end
	endgenerate
	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_RUN  = 4'b0010,
		H_RSTB = 4'b0100,
		H_RCAP = 4'b1000
	} pqm_hst_t;
	pqm_hst_t st_r, st_nxt;
	logic [2:0]  op_r, op_nxt;
	logic [3:0]  step_r, step_nxt, addr_r, addr_nxt, act_addr;
	logic [10:0] n_r, n_nxt;
	logic [PN_W-1:0] pn_r, pn_nxt;
	logic [15:0] word_r, word_nxt, wd_r, wd_nxt, act_data, swd_r, swd_nxt;
	logic        wr_r, wr_nxt, rd_r, rd_nxt, emp_r, emp_nxt, act_rd, act_last;
	assign bus.addr     = addr_r;
	assign bus.wdata    = wd_r;
	assign bus.wr       = wr_r;
	assign bus.rd       = rd_r;
	assign sw_rdata_out = swd_r;
	// step table
	always_comb begin
		act_rd = 1'b0; act_addr = pqm_pkg::REG_CONFIG; act_data = '0; act_last = 1'b0;
		case (op_r)
			pqm_pkg::OP_WAKE: case (step_r)
				4'h0: act_data[pqm_pkg::CFG_PWR_BIT] = 1'b1; // [R1]
				4'h1: act_addr = pqm_pkg::REG_PHY0; // [R3]
				4'h2: begin act_addr = pqm_pkg::REG_MMU; act_data[pqm_pkg::MMU_CMD_LSB +: 3] = pqm_pkg::CMD_RESET; end // [R4]
				4'h3: begin act_addr = pqm_pkg::REG_TCR; act_data[pqm_pkg::TCR_EN_BIT] = 1'b1; end // [R4]
				default: begin act_addr = pqm_pkg::REG_RCR; act_data[pqm_pkg::RCR_EN_BIT] = 1'b1; act_last = 1'b1; end
			endcase
			pqm_pkg::OP_SEND: case (step_r)
				4'h0: begin
					act_addr = pqm_pkg::REG_MMU;
					act_data[pqm_pkg::MMU_CMD_LSB +: 3] = pqm_pkg::CMD_ALLOC;
					act_data[pqm_pkg::N_W-1:0] = n_r;
				end
				4'h1: begin act_rd = 1'b1; act_addr = pqm_pkg::REG_INT; end // [R8]
				4'h2: begin act_rd = 1'b1; act_addr = pqm_pkg::REG_ARR; end
				4'h3: begin act_addr = pqm_pkg::REG_PNR; act_data[PN_W-1:0] = pn_r; end // [R9]
				4'h4: act_addr = pqm_pkg::REG_PTR; // [R9]
				4'h5: begin act_addr = pqm_pkg::REG_MMU; act_data[pqm_pkg::MMU_CMD_LSB +: 3] = pqm_pkg::CMD_ENQ; end
				default: begin act_addr = pqm_pkg::REG_INT; act_data[pqm_pkg::INT_ALLOC_BIT] = 1'b1; act_last = 1'b1; end
			endcase
			default: case (step_r)
				4'h0: begin act_rd = 1'b1; act_addr = pqm_pkg::REG_FIFO; end // [R14]
				4'h1: begin act_addr = pqm_pkg::REG_PNR; act_data[PN_W-1:0] = pn_r; end // [R14]
				4'h2: act_addr = pqm_pkg::REG_PTR;
				4'h3: begin act_rd = 1'b1; act_addr = pqm_pkg::REG_DATA; end
				4'h4: begin
					act_addr = pqm_pkg::REG_MMU;
					act_data[pqm_pkg::MMU_CMD_LSB +: 3] = (op_r == pqm_pkg::OP_TXSVC) ? pqm_pkg::CMD_RELEASE
						: pqm_pkg::CMD_RMREL; // [R15] [R22]
					act_last = (op_r != pqm_pkg::OP_TXSVC);
				end
				default: begin act_addr = pqm_pkg::REG_INT; act_data[pqm_pkg::INT_TX_BIT] = 1'b1; act_last = 1'b1; end // [R15]
			endcase
		endcase
	end
	// sequencer
	always_comb begin
		st_nxt = st_r; op_nxt = op_r; step_nxt = step_r; n_nxt = n_r; pn_nxt = pn_r; word_nxt = word_r;
		emp_nxt = emp_r; addr_nxt = addr_r; wd_nxt = wd_r; wr_nxt = 1'b0; rd_nxt = 1'b0;
		case (st_r)
			H_IDLE: begin
				if (sw_wr_in && sw_addr_in == pqm_pkg::HREG_CMD && sw_wdata_in[pqm_pkg::OP_LSB +: 3] != 3'h0
					&& sw_wdata_in[pqm_pkg::OP_LSB +: 3] <= pqm_pkg::OP_RXSVC) begin
					op_nxt   = sw_wdata_in[pqm_pkg::OP_LSB +: 3];
					n_nxt    = sw_wdata_in[pqm_pkg::N_W-1:0];
					step_nxt = '0;
					emp_nxt  = 1'b0;
					st_nxt   = H_RUN;
				end
			end
			H_RUN: begin
				addr_nxt = act_addr;
				wd_nxt   = act_data;
				if (act_rd) begin
					rd_nxt = 1'b1;
					st_nxt = H_RSTB;
				end else begin
					wr_nxt   = 1'b1;
					step_nxt = step_r + 4'h1;
					st_nxt   = act_last ? H_IDLE : H_RUN;
				end
			end
			H_RSTB: st_nxt = H_RCAP;
			H_RCAP: begin
				st_nxt   = H_RUN;
				step_nxt = step_r + 4'h1;
				if (op_r == pqm_pkg::OP_SEND) begin
					if (step_r == 4'h1 && !bus.rdata[pqm_pkg::INT_ALLOC_BIT]) begin
						step_nxt = step_r; // [R8]
					end else if (step_r == 4'h2) begin
						pn_nxt = bus.rdata[PN_W-1:0];
					end
				end else if (step_r == 4'h0) begin
					pn_nxt  = (op_r == pqm_pkg::OP_TXSVC) ? bus.rdata[pqm_pkg::FIFO_TX_LSB +: PN_W]
						: bus.rdata[pqm_pkg::FIFO_RX_LSB +: PN_W];
					emp_nxt = (op_r == pqm_pkg::OP_TXSVC) ? bus.rdata[pqm_pkg::FIFO_TXE_BIT]
						: bus.rdata[pqm_pkg::FIFO_RXE_BIT];
					if (emp_nxt) begin
						st_nxt = H_IDLE;
					end
				end else begin
					word_nxt = bus.rdata;
				end
			end
			default: st_nxt = H_IDLE;
		endcase
		swd_nxt = '0;
		if (sw_rd_in) begin
			case (sw_addr_in)
				pqm_pkg::HREG_STAT: begin
					swd_nxt[pqm_pkg::STAT_BUSY_BIT]  = (st_r != H_IDLE);
					swd_nxt[pqm_pkg::STAT_EMPTY_BIT] = emp_r;
					swd_nxt[PN_W-1:0]                = pn_r;
				end
				pqm_pkg::HREG_WORD: swd_nxt = word_r;
				default: swd_nxt = '0;
			endcase
		end
	end
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r <= H_IDLE; op_r <= '0; step_r <= '0; n_r <= '0; pn_r <= '0; word_r <= '0;
			emp_r <= 1'b0; addr_r <= '0; wd_r <= '0; wr_r <= 1'b0; rd_r <= 1'b0; swd_r <= '0;
		end else begin
			st_r <= st_nxt; op_r <= op_nxt; step_r <= step_nxt; n_r <= n_nxt; pn_r <= pn_nxt;
			word_r <= word_nxt; emp_r <= emp_nxt; addr_r <= addr_nxt; wd_r <= wd_nxt;
			wr_r <= wr_nxt; rd_r <= rd_nxt; swd_r <= swd_nxt;
		end
	end
endmodule : pqm_host

// *** rtl/pqm_pkg.sv ***
// shared constants for the packet queue manager ends
package pqm_pkg;
	// geometry
	localparam int ADDR_W  = 4;
	localparam int DATA_W  = 16;
	localparam int PKTS    = 8;
	localparam int PAGES   = 32;
	localparam int PAGE_SH = 8;
	localparam int N_W     = 11;
	// register offsets
	localparam logic [ADDR_W-1:0] REG_CONFIG = 4'h0;
	localparam logic [ADDR_W-1:0] REG_MMU    = 4'h1;
	localparam logic [ADDR_W-1:0] REG_PNR    = 4'h2;
	localparam logic [ADDR_W-1:0] REG_ARR    = 4'h3;
	localparam logic [ADDR_W-1:0] REG_FIFO   = 4'h4;
	localparam logic [ADDR_W-1:0] REG_PTR    = 4'h5;
	localparam logic [ADDR_W-1:0] REG_DATA   = 4'h6;
	localparam logic [ADDR_W-1:0] REG_INT    = 4'h7;
	localparam logic [ADDR_W-1:0] REG_TCR    = 4'h8;
	localparam logic [ADDR_W-1:0] REG_RCR    = 4'h9;
	localparam logic [ADDR_W-1:0] REG_CTRL   = 4'ha;
	localparam logic [ADDR_W-1:0] REG_PHY0   = 4'hb;
	// field positions
	localparam int CFG_PWR_BIT   = 0;
	localparam int PHY_PDN_BIT   = 11;
	localparam int TCR_EN_BIT    = 0;
	localparam int RCR_EN_BIT    = 0;
	localparam int CTRL_AREL_BIT = 0;
	localparam int PTR_WORD_BIT  = 1;
	localparam int MMU_CMD_LSB   = 13;
	localparam int ARR_BUSY_BIT  = 7;
	localparam int FIFO_RXE_BIT  = 15;
	localparam int FIFO_RX_LSB   = 8;
	localparam int FIFO_TXE_BIT  = 7;
	localparam int FIFO_TX_LSB   = 0;
	localparam int INT_RX_BIT    = 0;
	localparam int INT_TX_BIT    = 1;
	localparam int INT_TXE_BIT   = 2;
	localparam int INT_ALLOC_BIT = 3;
	// reset values
	localparam logic [DATA_W-1:0] CONFIG_RST = 16'h0000;
	localparam logic [DATA_W-1:0] PHY0_RST   = 16'h0800;
	localparam logic [DATA_W-1:0] CTL_RST    = 16'h0000;
	// mmu commands
	localparam logic [2:0] CMD_ALLOC   = 3'h1;
	localparam logic [2:0] CMD_RESET   = 3'h2;
	localparam logic [2:0] CMD_RMREL   = 3'h3;
	localparam logic [2:0] CMD_RELEASE = 3'h4;
	localparam logic [2:0] CMD_ENQ     = 3'h5;
	// host software port
	localparam logic [ADDR_W-1:0] HREG_CMD  = 4'h0;
	localparam logic [ADDR_W-1:0] HREG_STAT = 4'h1;
	localparam logic [ADDR_W-1:0] HREG_WORD = 4'h2;
	localparam int OP_LSB         = 12;
	localparam int STAT_BUSY_BIT  = 15;
	localparam int STAT_EMPTY_BIT = 14;
	localparam logic [2:0] OP_WAKE  = 3'h1;
	localparam logic [2:0] OP_SEND  = 3'h2;
	localparam logic [2:0] OP_TXSVC = 3'h3;
	localparam logic [2:0] OP_RXSVC = 3'h4;
endpackage : pqm_pkg

// *** test/pqm_checker.sv ***
// bus and pin assertions
`timescale 1ns/1ps
module pqm_checker (
	// clock and reset
	input wire logic        mclk_in,
	input wire logic        rst_n_in,
	// register bus
	input wire logic [3:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic        wr,
	input wire logic        rd,
	// device pins
	input wire logic        full_duplex_in,
	input wire logic        defer_in,
	input wire logic        tx_start_out,
	input wire logic        rx_start_in,
	input wire logic        rx_page_req_in,
	input wire logic        rx_overrun_in,
	input wire logic        rx_end_in,
	input wire logic        rx_drop_out,
	input wire logic        core_clk_en_out,
	input wire logic        rx_clk_en_out,
	input wire logic        tx_clk_en_out,
	input wire logic        phy_powerdown_out
);
	logic ten_r, ten_nxt;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	always_comb ten_nxt = (wr && addr == pqm_pkg::REG_TCR) ? wdata[0] : ten_r;
	always_ff @(posedge mclk_in or negedge rst_n_in)
		if (!rst_n_in) ten_r <= 1'b0;
		else ten_r <= ten_nxt;
	sequence s_phy_mmu;
		wr && addr == pqm_pkg::REG_PHY0 && !wdata[11] ##1 wr && addr == pqm_pkg::REG_MMU && wdata[15:13] == 3'h2;
	endsequence
	sequence s_enables;
		wr && addr == pqm_pkg::REG_TCR && wdata[0] ##1 wr && addr == pqm_pkg::REG_RCR && wdata[0];
	endsequence
	property p_wake;
		wr && addr == pqm_pkg::REG_CONFIG && wdata[0] |=> s_phy_mmu ##1 s_enables;
	endproperty
	property p_clk;
		wr && addr == pqm_pkg::REG_CONFIG && wdata[0] |-> ##[1:2] core_clk_en_out && rx_clk_en_out && tx_clk_en_out;
	endproperty
	property p_phy;
		wr && addr == pqm_pkg::REG_PHY0 && !wdata[11] |-> ##[1:2] !phy_powerdown_out;
	endproperty
	property p_txen;
		tx_start_out |-> $past(ten_r) || $past(ten_r, 2);
	endproperty
	property p_defer;
		tx_start_out |-> $past(full_duplex_in) || !$past(defer_in);
	endproperty
	property p_pulse;
		tx_start_out |=> !tx_start_out;
	endproperty
	property p_rdidle;
		!$past(rd) |-> rdata == 16'h0000;
	endproperty
	property p_drop;
		rx_drop_out |-> $past(rx_start_in) || $past(rx_page_req_in) || $past(rx_end_in) || $past(rx_overrun_in);
	endproperty
	a_wake: assert property (p_wake) else $error("wake order wrong");
	a_clk: assert property (p_clk) else $error("clocks not enabled");
	a_phy: assert property (p_phy) else $error("phy still down");
	a_txen: assert property (p_txen) else $error("start while disabled");
	a_defer: assert property (p_defer) else $error("start during deferral");
	a_pulse: assert property (p_pulse) else $error("start too long");
	a_rdidle: assert property (p_rdidle) else $error("read data not idle");
	a_drop: assert property (p_drop) else $error("drop without cause");
endmodule : pqm_checker

// *** test/testbench.sv ***
// self-checking bench for host and device
`timescale 1ns/1ps
module testbench;
	logic mclk_in = 1'b0, rst_n_in = 1'b0, sw_wr_in = 1'b0, sw_rd_in = 1'b0, defer_in = 1'b1, tx_done_in = 1'b0;
	logic full_duplex_in = 1'b0, tx_ok_in = 1'b1, rx_start_in = 1'b0, rx_page_req_in = 1'b0, rx_overrun_in = 1'b0;
	logic rx_end_in = 1'b0, rx_crc_ok_in = 1'b0, tx_start_out, rx_drop_out, core_clk_en_out, rx_clk_en_out;
	logic tx_clk_en_out, phy_powerdown_out;
	logic [3:0] sw_addr_in = 4'h0;
	logic [2:0] tx_pnr_out;
	logic [15:0] sw_wdata_in = 16'h0000, tx_status_in = 16'h0000, rx_status_in = 16'h0000, rx_bytes_in = 16'h0000;
	logic [15:0] sw_rdata_out, s, w;
	int error_cnt = 0, checked = 0, cyc = 0, starts = 0, drops = 0;
	pqm_bus_if bif ();
	pqm_dev u_pqm_dev (.mclk_in, .rst_n_in, .bus(bif), .full_duplex_in, .defer_in, .tx_done_in, .tx_ok_in,
		.tx_status_in, .tx_start_out, .tx_pnr_out, .rx_start_in, .rx_page_req_in, .rx_overrun_in, .rx_end_in,
		.rx_crc_ok_in, .rx_status_in, .rx_bytes_in, .rx_drop_out, .core_clk_en_out, .rx_clk_en_out,
		.tx_clk_en_out, .phy_powerdown_out);
	pqm_host u_pqm_host (.mclk_in, .rst_n_in, .bus(bif), .sw_addr_in, .sw_wdata_in, .sw_wr_in, .sw_rd_in,
		.sw_rdata_out);
	pqm_checker u_pqm_checker (.mclk_in, .rst_n_in, .addr(bif.addr), .wdata(bif.wdata), .rdata(bif.rdata),
		.wr(bif.wr), .rd(bif.rd), .full_duplex_in, .defer_in, .tx_start_out, .rx_start_in, .rx_page_req_in,
		.rx_overrun_in, .rx_end_in, .rx_drop_out, .core_clk_en_out, .rx_clk_en_out, .tx_clk_en_out,
		.phy_powerdown_out);
	always #5 mclk_in = ~mclk_in;
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (tx_start_out === 1'b1) starts <= starts + 1;
		if (rx_drop_out === 1'b1) drops <= drops + 1;
		if (cyc == 20000) begin
			error_cnt++;
			results();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic sw_rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge mclk_in);
		sw_rd_in <= 1'b1;
		sw_addr_in <= a;
		@(posedge mclk_in);
		sw_rd_in <= 1'b0;
		#1 d = sw_rdata_out;
	endtask : sw_rd
	task automatic run(input logic [2:0] op, input logic [10:0] n, output logic [15:0] st);
		@(posedge mclk_in);
		sw_wr_in <= 1'b1;
		sw_addr_in <= pqm_pkg::HREG_CMD;
		sw_wdata_in <= {1'b0, op, 1'b0, n};
		@(posedge mclk_in);
		sw_wr_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		st = 16'h8000;
		for (int i = 0; i < 300 && st[15] !== 1'b0; i++) sw_rd(pqm_pkg::HREG_STAT, st);
		check(16'(st[15]), 16'h0000);
	endtask : run
	task automatic rx_frame(input logic ok, input logic [15:0] st, input logic ovr);
		@(posedge mclk_in);
		rx_start_in <= 1'b1;
		@(posedge mclk_in);
		rx_start_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		rx_page_req_in <= 1'b1;
		@(posedge mclk_in);
		rx_page_req_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		{rx_end_in, rx_overrun_in} <= {!ovr, ovr};
		rx_crc_ok_in <= ok;
		rx_status_in <= st;
		rx_bytes_in <= 16'h0140;
		@(posedge mclk_in);
		{rx_end_in, rx_overrun_in} <= 2'h0;
		repeat (3) @(posedge mclk_in);
	endtask : rx_frame
	task automatic t_wake();
		check(16'({core_clk_en_out, phy_powerdown_out}), 16'h0001);
		run(pqm_pkg::OP_WAKE, 11'h000, s);
		check(16'({core_clk_en_out, rx_clk_en_out, tx_clk_en_out, phy_powerdown_out}), 16'h000e);
	endtask : t_wake
	task automatic t_tx();
		run(pqm_pkg::OP_SEND, 11'h12c, s);
		repeat (20) @(posedge mclk_in);
		check(16'(starts), 16'h0000);
		defer_in <= 1'b0;
		repeat (6) @(posedge mclk_in);
		check(16'(starts), 16'h0001);
		check(16'(tx_pnr_out), 16'(s[2:0]));
		tx_status_in <= 16'h5a3c;
		tx_done_in <= 1'b1;
		@(posedge mclk_in);
		tx_done_in <= 1'b0;
		run(pqm_pkg::OP_TXSVC, 11'h000, w);
		check(16'(w[2:0]), 16'(s[2:0]));
		sw_rd(pqm_pkg::HREG_WORD, w);
		check(w, 16'h5a3c);
		run(pqm_pkg::OP_TXSVC, 11'h000, w);
		check(16'(w[14]), 16'h0001);
	endtask : t_tx
	task automatic t_rx();
		rx_frame(1'b1, 16'h00a5, 1'b0);
		run(pqm_pkg::OP_RXSVC, 11'h000, s);
		check(16'(s[14]), 16'h0000);
		sw_rd(pqm_pkg::HREG_WORD, w);
		check(w, 16'h00a5);
		run(pqm_pkg::OP_RXSVC, 11'h000, s);
		check(16'(s[14]), 16'h0001);
		rx_frame(1'b0, 16'h0bad, 1'b0);
		check(16'(drops), 16'h0001);
		rx_frame(1'b1, 16'h0000, 1'b1);
		check(16'(drops), 16'h0002);
		run(pqm_pkg::OP_RXSVC, 11'h000, s);
		check(16'(s[14]), 16'h0001);
	endtask : t_rx
	task automatic results();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : results
	initial begin
		repeat (3) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		t_wake();
		t_tx();
		t_rx();
		results();
	end
endmodule : testbench
